//--- design/caf_alu.sv
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
module caf_alu (
  input wire aclk, // 125 MHz clock
  input wire aresetn, // sync reset, active low
  input wire [5:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // byte strobes
  input wire s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire s_axi_bready, // response ready
  input wire [5:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read valid
  input wire s_axi_rready // read ready
);
  import caf_pkg::*;
  // every property runs on aclk and rests while reset is low
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  logic [31:0] ctrl_q;
  logic [15:0] dst_q, src_q, sr_q, res_q;
  logic [3:0] cyc_q;
  logic aw_hold_q, w_hold_q;
  logic [5:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q, rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] bresp_q, rresp_q;

  // control fields: op, width, register dest, event, mode, go
  caf_cmd_t cmd;
  caf_ev_t ev;
  caf_am_t am;
  logic go;
  assign cmd = {caf_op_t'(ctrl_q[3:0]), ctrl_q[4], ctrl_q[5]};
  assign ev = caf_ev_t'(ctrl_q[10:8]);
  assign am = caf_am_t'(ctrl_q[14:12]);

  // helpers used for several results
  function automatic logic f_msb(input logic [15:0] v, input logic bw);
    f_msb = bw ? v[CAF_BYTE_MSB] : v[CAF_WORD_MSB];
  endfunction : f_msb
  function automatic logic f_zero(input logic [15:0] v, input logic bw);
    f_zero = bw ? (v[7:0] == 8'h00) : (v == 16'h0000);
  endfunction : f_zero

  // adder shared by the subtract family
  logic c_in, b_w;
  logic [15:0] add_b, add_cin;
  logic [16:0] sum_w;
  logic [8:0] sum_b;
  logic [15:0] sum;
  logic cout, ovf;
  assign c_in = sr_q[CAF_SR_C];
  assign b_w = cmd.byte_w;
  assign add_b = (cmd.op == CAF_OP_SBC) ?
                 (b_w ? CAF_BYTE_ONES : CAF_WORD_ONES) : ~src_q;
  assign add_cin = (cmd.op == CAF_OP_SUB) ? 16'h0001 : {15'h0000, c_in};
  assign sum_w = {1'b0, dst_q} + {1'b0, add_b} + {1'b0, add_cin};
  assign sum_b = {1'b0, dst_q[7:0]} + {1'b0, add_b[7:0]} +
                 {1'b0, add_cin[7:0]};
  assign sum = b_w ? {8'h00, sum_b[7:0]} : sum_w[15:0];
  assign cout = b_w ? sum_b[8] : sum_w[16];
  assign ovf = (f_msb(dst_q, b_w) == f_msb(add_b, b_w)) &&
               (f_msb(sum, b_w) != f_msb(dst_q, b_w));

  // rotate and logic results
  logic [15:0] rot, swp, sign_extend_op, xr;
  assign rot = b_w ? {8'h00, c_in, dst_q[7:1]} : {c_in, dst_q[15:1]};
  assign swp = {dst_q[7:0], dst_q[15:8]};
  assign sign_extend_op = {{8{dst_q[CAF_BYTE_MSB]}}, dst_q[7:0]};
  assign xr = b_w ? {8'h00, dst_q[7:0] ^ src_q[7:0]} : dst_q ^ src_q;

  // result and flag selection
  logic [15:0] res_d, sr_d;
  logic wr_d;
  logic n_r, z_r;
  always_comb begin
    res_d = dst_q;
    sr_d = sr_q;
    wr_d = 1'b1;
    case (cmd.op)
      CAF_OP_RRC: begin
        res_d = rot;
        sr_d[CAF_SR_C] = dst_q[0];
        sr_d[CAF_SR_V] = ~f_msb(dst_q, b_w) & c_in;
      end
      CAF_OP_SBC, CAF_OP_SUB, CAF_OP_SUBTRACT_WITH_CARRY: begin
        res_d = sum;
        sr_d[CAF_SR_C] = cout;
        sr_d[CAF_SR_V] = ovf;
      end
      CAF_OP_SET_CARRY_OP: begin
        wr_d = 1'b0;
        sr_d[CAF_SR_C] = 1'b1;
      end
      CAF_OP_SET_ZERO_OP: begin
        wr_d = 1'b0;
        sr_d[CAF_SR_Z] = 1'b1;
      end
      CAF_OP_SET_NEGATIVE_OP: begin
        wr_d = 1'b0;
        sr_d[CAF_SR_N] = 1'b1;
      end
      CAF_OP_BYTE_SWAP_OP: res_d = swp;
      CAF_OP_SXT: begin
        res_d = sign_extend_op;
        sr_d[CAF_SR_C] = (sign_extend_op != 16'h0000);
        sr_d[CAF_SR_V] = 1'b0;
      end
      CAF_OP_TST: begin
        wr_d = 1'b0;
        sr_d[CAF_SR_C] = 1'b1;
        sr_d[CAF_SR_V] = 1'b0;
      end
      CAF_OP_XOR: begin
        res_d = xr;
        sr_d[CAF_SR_C] = ~f_zero(xr, b_w);
        sr_d[CAF_SR_V] = f_msb(dst_q, b_w) & f_msb(src_q, b_w);
      end
      default: wr_d = 1'b0;
    endcase
    n_r = f_msb((cmd.op == CAF_OP_TST) ? dst_q : res_d,
                b_w && cmd.op != CAF_OP_SXT && cmd.op != CAF_OP_BYTE_SWAP_OP);
    z_r = f_zero((cmd.op == CAF_OP_TST) ? dst_q : res_d,
                 b_w && cmd.op != CAF_OP_SXT && cmd.op != CAF_OP_BYTE_SWAP_OP);
    if (cmd.op != CAF_OP_SET_CARRY_OP && cmd.op != CAF_OP_SET_ZERO_OP &&
        cmd.op != CAF_OP_SET_NEGATIVE_OP && cmd.op != CAF_OP_BYTE_SWAP_OP &&
        cmd.op != CAF_OP_NOP) begin
      sr_d[CAF_SR_N] = n_r;
      sr_d[CAF_SR_Z] = z_r;
    end
    // clear upper byte
    // memory byte writes would keep it; only register dest is cleared
    if (b_w && cmd.op != CAF_OP_SXT && cmd.op != CAF_OP_BYTE_SWAP_OP &&
        !cmd.dst_reg) begin
      res_d[15:8] = dst_q[15:8];
    end
    sr_d[CAF_SR_GIE] = sr_q[CAF_SR_GIE];
    sr_d[CAF_SR_PROCESSOR_OFF_BIT] = sr_q[CAF_SR_PROCESSOR_OFF_BIT];
    sr_d[CAF_SR_OSCILLATOR_OFF_BIT] = sr_q[CAF_SR_OSCILLATOR_OFF_BIT];
  end

  // cycle lookup
  logic [3:0] cyc_w;
  logic ext_w;
  caf_cycles u_cyc (
    .ev(ev),
    .am(am),
    .cycles(cyc_w),
    .ext_word(ext_w)
  );

  // axi write path: address and data in either order
  logic aw_fire, w_fire, do_wr;
  logic [5:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;
  assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
  assign s_axi_wready = ~w_hold_q & ~bvalid_q;
  assign aw_fire = s_axi_awvalid & s_axi_awready;
  assign w_fire = s_axi_wvalid & s_axi_wready;
  assign do_wr = (aw_hold_q | aw_fire) & (w_hold_q | w_fire);
  assign wa = aw_hold_q ? awaddr_q : s_axi_awaddr;
  assign wd = w_hold_q ? wdata_q : s_axi_wdata;
  assign ws = w_hold_q ? wstrb_q : s_axi_wstrb;
  logic wa_ok;
  assign wa_ok = (wa == CAF_A_CTRL) || (wa == CAF_A_DST) ||
                 (wa == CAF_A_SRC) || (wa == CAF_A_SR);
  // writing ctrl with bit 31 starts one operation next cycle
  assign go = do_wr && (wa == CAF_A_CTRL) && ws[3] && wd[31];

  function automatic logic [15:0] f_merge(input logic [15:0] o,
      input logic [31:0] d, input logic [3:0] s);
    f_merge = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
  endfunction : f_merge

  logic run_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 6'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= CAF_RESP_OK;
    end else begin
      if (do_wr) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wa_ok ? CAF_RESP_OK : CAF_RESP_ERR;
      end else begin
        if (aw_fire) begin
          aw_hold_q <= 1'b1;
          awaddr_q <= s_axi_awaddr;
        end
        if (w_fire) begin
          w_hold_q <= 1'b1;
          wdata_q <= s_axi_wdata;
          wstrb_q <= s_axi_wstrb;
        end
        if (bvalid_q && s_axi_bready) begin
          bvalid_q <= 1'b0;
        end
      end
    end
  end

  // registers and execution; an operation overrides a same-cycle write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= 32'h00000000;
      dst_q <= 16'h0000;
      src_q <= 16'h0000;
      sr_q <= CAF_SR_RESET;
      res_q <= 16'h0000;
      cyc_q <= 4'h0;
      run_q <= 1'b0;
    end else begin
      run_q <= go;
      if (do_wr && wa == CAF_A_CTRL) begin
        ctrl_q <= {1'b0, wd[30:0]};
      end
      if (do_wr && wa == CAF_A_DST) begin
        dst_q <= f_merge(dst_q, wd, ws);
      end
      if (do_wr && wa == CAF_A_SRC) begin
        src_q <= f_merge(src_q, wd, ws);
      end
      if (do_wr && wa == CAF_A_SR && !run_q) begin
        sr_q <= f_merge(sr_q, wd, ws);
      end
      if (run_q) begin
        sr_q <= sr_d;
        res_q <= wr_d ? res_d : dst_q;
        cyc_q <= cyc_w;
        if (wr_d) begin
          dst_q <= res_d;
        end
      end
    end
  end

  // axi read path
  logic [5:0] ra;
  logic [31:0] rd_w;
  logic ra_ok;
  assign s_axi_arready = ~rvalid_q;
  assign ra = s_axi_araddr;
  assign ra_ok = (ra == CAF_A_CTRL) || (ra == CAF_A_DST) ||
                 (ra == CAF_A_SRC) || (ra == CAF_A_SR) ||
                 (ra == CAF_A_RES) || (ra == CAF_A_CYC);
  assign rd_w = (ra == CAF_A_CTRL) ? {1'b0, ctrl_q[30:0]} :
                (ra == CAF_A_DST) ? {16'h0000, dst_q} :
                (ra == CAF_A_SRC) ? {16'h0000, src_q} :
                (ra == CAF_A_SR) ? {16'h0000, sr_q} :
                (ra == CAF_A_RES) ? {16'h0000, res_q} :
                (ra == CAF_A_CYC) ? {27'h0000000, ext_w, cyc_q} :
                32'h00000000;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= CAF_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_w;
      rresp_q <= ra_ok ? CAF_RESP_OK : CAF_RESP_ERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // checks on the execution step, the cycle lookup and the write channel
  AST_MODE_BITS: assert property (run_q |=>
    $stable(sr_q[CAF_SR_OSCILLATOR_OFF_BIT:CAF_SR_GIE])) else $error("mode bits changed");
  AST_SWAP: assert property (run_q && cmd.op == CAF_OP_BYTE_SWAP_OP |=>
    dst_q == {$past(dst_q[7:0]), $past(dst_q[15:8])} && sr_q == $past(sr_q))
    else $error("byte swap wrong");
  AST_SXT_C: assert property (run_q && cmd.op == CAF_OP_SXT |=>
    sr_q[CAF_SR_C] == ~sr_q[CAF_SR_Z] && !sr_q[CAF_SR_V])
    else $error("sign extend carry wrong");
  AST_TST: assert property (run_q && cmd.op == CAF_OP_TST |=>
    sr_q[CAF_SR_C] && !sr_q[CAF_SR_V] && $stable(dst_q))
    else $error("test flags wrong");
  AST_RRC_MSB: assert property (
    run_q && cmd.op == CAF_OP_RRC && !cmd.byte_w |=>
    dst_q[15] == $past(sr_q[0]) && sr_q[0] == $past(dst_q[0]))
    else $error("rotate wrong");
  AST_SUB: assert property (
    run_q && cmd.op == CAF_OP_SUB && !cmd.byte_w |=>
    dst_q == 16'($past(dst_q) - $past(src_q)) &&
    sr_q[0] == ($past(dst_q) >= $past(src_q)))
    else $error("subtract wrong");
  AST_SET_CARRY_OP: assert property (run_q && cmd.op == CAF_OP_SET_CARRY_OP |=>
    sr_q == ($past(sr_q) | 16'h0001)) else $error("set carry wrong");
  AST_BYTE_HI: assert property (
    run_q && cmd.byte_w && cmd.dst_reg && cmd.op == CAF_OP_XOR |=>
    dst_q[15:8] == 8'h00) else $error("upper byte not cleared");
  AST_INTERRUPT_RETURN_OP_CYC: assert property (ev == CAF_EV_INTERRUPT_RETURN_OP |->
    cyc_w == CAF_CYC_INTERRUPT_RETURN_OP) else $error("return cycles wrong");
  AST_BRESP: assert property (do_wr |=> s_axi_bvalid)
    else $error("no write response");
  COV_SUB: cover property (run_q && cmd.op == CAF_OP_SUB);
  COV_RRC_B: cover property (run_q && cmd.op == CAF_OP_RRC && cmd.byte_w);
  COV_XOR: cover property (run_q && cmd.op == CAF_OP_XOR);
  COV_RD: cover property (s_axi_rvalid && s_axi_rready);
endmodule : caf_alu

//--- design/caf_cycles.sv
`timescale 1ns/100ps
module caf_cycles
  import caf_pkg::*;
(
  input wire caf_pkg::caf_ev_t ev, // event or format
  input wire caf_pkg::caf_am_t am, // addressing mode
  output logic [3:0] cycles, // master-clock cycles
  output logic ext_word // one extension word
);
  // event or format, and mode only
  // operation never enters here, only format and mode
  always_comb begin
    cycles = CAF_CYC_1;
    case (ev)
      CAF_EV_INTERRUPT_RETURN_OP: cycles = CAF_CYC_INTERRUPT_RETURN_OP;
      CAF_EV_IRQ: cycles = CAF_CYC_IRQ;
      CAF_EV_WDT: cycles = CAF_CYC_WDT;
      CAF_EV_RST: cycles = CAF_CYC_RST;
      CAF_EV_FMT2: begin
        if (am == CAF_AM_REG) begin
          cycles = CAF_CYC_1;
        end else if (am == CAF_AM_IND || am == CAF_AM_INC) begin
          cycles = CAF_CYC_3;
        end else begin
          cycles = CAF_CYC_4;
        end
      end
      CAF_EV_PUSH: begin
        if (am == CAF_AM_REG) begin
          cycles = CAF_CYC_3;
        end else if (am == CAF_AM_IND || am == CAF_AM_INC ||
                     am == CAF_AM_IMM) begin
          cycles = CAF_CYC_4;
        end else begin
          cycles = CAF_CYC_5;
        end
      end
      CAF_EV_CALL: begin
        if (am == CAF_AM_REG || am == CAF_AM_IND) begin
          cycles = CAF_CYC_4;
        end else begin
          cycles = CAF_CYC_5;
        end
      end
      default: cycles = CAF_CYC_1;
    endcase
  end
  assign ext_word = (am == CAF_AM_IDX) || (am == CAF_AM_SYM) ||
                    (am == CAF_AM_ABS) || (am == CAF_AM_IMM);
endmodule : caf_cycles

//--- design/caf_pkg.sv
package caf_pkg;
  localparam int unsigned CAF_W = 16;
  localparam int unsigned CAF_BYTE_MSB = 7;
  localparam int unsigned CAF_WORD_MSB = 15;
  localparam logic [15:0] CAF_WORD_ONES = 16'hffff;
  localparam logic [15:0] CAF_BYTE_ONES = 16'h00ff;
  localparam logic [15:0] CAF_LOW_MASK = 16'h00ff;
  // status register bit positions
  localparam int unsigned CAF_SR_C = 0;
  localparam int unsigned CAF_SR_Z = 1;
  localparam int unsigned CAF_SR_N = 2;
  localparam int unsigned CAF_SR_GIE = 3;
  localparam int unsigned CAF_SR_PROCESSOR_OFF_BIT = 4;
  localparam int unsigned CAF_SR_OSCILLATOR_OFF_BIT = 5;
  localparam int unsigned CAF_SR_V = 8;
  localparam logic [15:0] CAF_SR_RESET = 16'h0000;
  // cycle counts
  localparam logic [3:0] CAF_CYC_INTERRUPT_RETURN_OP = 4'h5;
  localparam logic [3:0] CAF_CYC_IRQ = 4'h6;
  localparam logic [3:0] CAF_CYC_WDT = 4'h4;
  localparam logic [3:0] CAF_CYC_RST = 4'h4;
  localparam logic [3:0] CAF_CYC_1 = 4'h1;
  localparam logic [3:0] CAF_CYC_3 = 4'h3;
  localparam logic [3:0] CAF_CYC_4 = 4'h4;
  localparam logic [3:0] CAF_CYC_5 = 4'h5;
  // axi4-lite map
  localparam logic [5:0] CAF_A_CTRL = 6'h00;
  localparam logic [5:0] CAF_A_DST = 6'h04;
  localparam logic [5:0] CAF_A_SRC = 6'h08;
  localparam logic [5:0] CAF_A_SR = 6'h0c;
  localparam logic [5:0] CAF_A_RES = 6'h10;
  localparam logic [5:0] CAF_A_CYC = 6'h14;
  localparam logic [1:0] CAF_RESP_OK = 2'b00;
  localparam logic [1:0] CAF_RESP_ERR = 2'b10;

  typedef enum logic [3:0] {
    CAF_OP_RRC, CAF_OP_SBC, CAF_OP_SET_CARRY_OP, CAF_OP_SET_ZERO_OP, CAF_OP_SET_NEGATIVE_OP,
    CAF_OP_SUB, CAF_OP_SUBTRACT_WITH_CARRY, CAF_OP_BYTE_SWAP_OP, CAF_OP_SXT, CAF_OP_TST,
    CAF_OP_XOR, CAF_OP_NOP
  } caf_op_t;

  typedef enum logic [2:0] {
    CAF_AM_REG, CAF_AM_IND, CAF_AM_INC, CAF_AM_IMM,
    CAF_AM_IDX, CAF_AM_SYM, CAF_AM_ABS
  } caf_am_t;

  typedef enum logic [2:0] {
    CAF_EV_INTERRUPT_RETURN_OP, CAF_EV_IRQ, CAF_EV_WDT, CAF_EV_RST,
    CAF_EV_FMT2, CAF_EV_PUSH, CAF_EV_CALL
  } caf_ev_t;

  typedef struct packed {
    caf_op_t op;
    logic byte_w;
    logic dst_reg;
  } caf_cmd_t;

  typedef struct packed {
    logic [15:0] res;
    logic [15:0] sr;
    logic wr_dst;
  } caf_out_t;
endpackage : caf_pkg

//--- verif/caf_bus_model.sv
`timescale 1ns/100ps
// lite-bus master standing in for the decoder and sequencer side
module caf_bus_model (
  input wire aclk, // bus clock
  output logic [5:0] awaddr, // aw addr
  output logic awvalid, // aw valid
  input wire awready, // aw ready
  output logic [31:0] wdata, // w data
  output logic [3:0] wstrb, // w strobes
  output logic wvalid, // w valid
  input wire wready, // w ready
  input wire [1:0] bresp, // b resp
  input wire bvalid, // b valid
  output logic bready, // b ready
  output logic [5:0] araddr, // ar addr
  output logic arvalid, // ar valid
  input wire arready, // ar ready
  input wire [31:0] rdata, // r data
  input wire [1:0] rresp, // r resp
  input wire rvalid, // r valid
  output logic rready // r ready
);
  // idle bus at time zero
  initial begin
    awaddr = 6'h3f;
    awvalid = 1'b0;
    wdata = 32'hffff_ffff;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 6'h3f;
    arvalid = 1'b0;
    rready = 1'b0;
  end

  // readies are looked at mid-cycle, where they already hold the value
  // that the next rising edge samples; each call first lets an edge pass
  // so no signal is driven twice in one time step
  task automatic bus_write(input logic [5:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [1:0] r);
    logic aw_p;
    logic w_p;
    logic aw_hit;
    logic w_hit;
    logic b_hit;
    @(posedge aclk);
    aw_p = 1'b1;
    w_p = 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw_p | w_p) begin
      @(negedge aclk);
      aw_hit = aw_p & awready;
      w_hit = w_p & wready;
      @(posedge aclk);
      if (aw_hit) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
        aw_p = 1'b0;
      end
      if (w_hit) begin
        wvalid <= 1'b0;
        wdata <= ~d;
        w_p = 1'b0;
      end
    end
    b_hit = 1'b0;
    while (!b_hit) begin
      @(negedge aclk);
      b_hit = bvalid;
      r = bresp;
      @(posedge aclk);
    end
    bready <= 1'b0;
  endtask : bus_write

  // read: address phase, then hold rready until the data is taken
  task automatic bus_read(input logic [5:0] a, output logic [31:0] d,
      output logic [1:0] r);
    logic hit;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    hit = 1'b0;
    while (!hit) begin
      @(negedge aclk);
      hit = arready;
      @(posedge aclk);
    end
    arvalid <= 1'b0;
    araddr <= ~a;
    hit = 1'b0;
    while (!hit) begin
      @(negedge aclk);
      hit = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
    end
    rready <= 1'b0;
  endtask : bus_read
endmodule : caf_bus_model

//--- verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import caf_pkg::*;
  logic aclk;
  logic aresetn;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  int n_mismatch = 0;
  int check_count = 0;

  // block under test and the master that talks to it
  caf_alu u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  caf_bus_model u_bus (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready);

  // 125 mhz clock
  initial aclk = 1'b0;
  always #4 aclk = ~aclk;

  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    if (n_mismatch == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude

  task automatic rd_chk(input string what, input logic [5:0] a,
      input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    u_bus.bus_read(a, d, r);
    check({what, " rresp"}, {30'h0, r}, {30'h0, CAF_RESP_OK});
    check(what, d, exp);
  endtask : rd_chk

  task automatic wr(input logic [5:0] a, input logic [31:0] d,
      input logic [1:0] exp);
    logic [1:0] r;
    u_bus.bus_write(a, d, 4'hf, r);
    check("bresp", {30'h0, r}, {30'h0, exp});
  endtask : wr

  // load operands and status, then start one operation
  task automatic exec(input caf_op_t op, input logic bw, input logic dr,
      input caf_ev_t ev, input caf_am_t am, input logic [15:0] d, s, sr);
    wr(CAF_A_DST, {16'h0, d}, CAF_RESP_OK);
    wr(CAF_A_SRC, {16'h0, s}, CAF_RESP_OK);
    wr(CAF_A_SR, {16'h0, sr}, CAF_RESP_OK);
    wr(CAF_A_CTRL, {1'b1, 16'h0, am, 1'b0, ev, 2'b00, dr, bw, op},
       CAF_RESP_OK);
  endtask : exec

  // expected {status, destination}; status bits c0 z1 n2 v8
  function automatic logic [31:0] alu_ref(input caf_op_t op, input logic bw,
      input logic dr, input logic [15:0] d, s, sr);
    logic [15:0] m, a, y, r, o;
    logic [16:0] sum;
    int hb;
    o = sr;
    hb = bw ? 7 : 15;
    m = bw ? CAF_BYTE_ONES : CAF_WORD_ONES;
    a = d & m;
    y = (op == CAF_OP_SBC) ? m : ~s & m;
    sum = a + y + ((op == CAF_OP_SUB) ? 17'h1 : {16'h0, sr[0]});
    r = a;
    case (op)
      CAF_OP_RRC: begin
        r = (a >> 1) | ({15'h0, sr[0]} << hb);
        o[0] = a[0];
        o[8] = !a[hb] & sr[0];
      end
      CAF_OP_SBC, CAF_OP_SUB, CAF_OP_SUBTRACT_WITH_CARRY: begin
        r = sum[15:0] & m;
        o[0] = sum[hb+1];
        o[8] = (a[hb] == y[hb]) && (r[hb] != a[hb]);
      end
      CAF_OP_SET_CARRY_OP: o[0] = 1'b1;
      CAF_OP_SET_ZERO_OP: o[1] = 1'b1;
      CAF_OP_SET_NEGATIVE_OP: o[2] = 1'b1;
      CAF_OP_BYTE_SWAP_OP: r = {d[7:0], d[15:8]};
      CAF_OP_SXT: begin
        r = {{8{d[7]}}, d[7:0]};
        hb = 15;
        m = CAF_WORD_ONES;
        o[8] = 1'b0;
      end
      CAF_OP_TST: o[8] = 1'b0;
      CAF_OP_XOR: begin
        r = a ^ (s & m);
        o[8] = a[hb] & s[hb];
      end
      default: r = a;
    endcase
    if (!(op inside {CAF_OP_SET_CARRY_OP, CAF_OP_SET_ZERO_OP, CAF_OP_SET_NEGATIVE_OP, CAF_OP_BYTE_SWAP_OP,
        CAF_OP_NOP})) begin
      o[2] = r[hb];
      o[1] = ((r & m) == 16'h0);
    end
    if (op inside {CAF_OP_SXT, CAF_OP_XOR}) o[0] = !o[1];
    if (op == CAF_OP_TST) o[0] = 1'b1;
    // status-only operations leave the destination alone
    if (op inside {CAF_OP_SET_CARRY_OP, CAF_OP_SET_ZERO_OP, CAF_OP_SET_NEGATIVE_OP, CAF_OP_TST})
      r = d;
    else if (bw && !dr && op != CAF_OP_SXT && op != CAF_OP_BYTE_SWAP_OP)
      r = {d[15:8], r[7:0]};
    return {o, r};
  endfunction : alu_ref

  // one register-mode operation, judged on destination, status, source
  task automatic chk_op(input caf_op_t op, input logic bw, input logic dr,
      input logic [15:0] d, s, sr);
    logic [31:0] e;
    e = alu_ref(op, bw, dr, d, s, sr);
    exec(op, bw, dr, CAF_EV_FMT2, CAF_AM_REG, d, s, sr);
    rd_chk("result", CAF_A_RES, {16'h0, e[15:0]});
    rd_chk("dst", CAF_A_DST, {16'h0, e[15:0]});
    rd_chk("sr", CAF_A_SR, {16'h0, e[31:16]});
    rd_chk("src", CAF_A_SRC, {16'h0, s});
  endtask : chk_op

  task automatic t_reset();
    rd_chk("dst reset", CAF_A_DST, 32'h0);
    rd_chk("src reset", CAF_A_SRC, 32'h0);
    rd_chk("sr reset", CAF_A_SR, 32'h0);
  endtask : t_reset

  // unmapped and read-only places are refused without side effect
  task automatic t_bus();
    logic [31:0] d;
    logic [1:0] r;
    wr(CAF_A_DST, 32'hffff_a5c3, CAF_RESP_OK);
    wr(6'h18, 32'h0000_1234, CAF_RESP_ERR);
    wr(CAF_A_RES, 32'h0000_0000, CAF_RESP_ERR);
    u_bus.bus_read(6'h3c, d, r);
    check("unmapped rresp", {30'h0, r}, {30'h0, CAF_RESP_ERR});
    rd_chk("dst kept", CAF_A_DST, 32'h0000_a5c3);
    // only the strobed lane of a register may change
    u_bus.bus_write(CAF_A_DST, 32'h0000_1e7b, 4'h2, r);
    check("lane bresp", {30'h0, r}, {30'h0, CAF_RESP_OK});
    rd_chk("dst lane", CAF_A_DST, 32'h0000_1ec3);
  endtask : t_bus

  task automatic t_rotate();
    chk_op(CAF_OP_RRC, 1'b0, 1'b0, 16'h0002, 16'h0, 16'h0039);
    chk_op(CAF_OP_RRC, 1'b0, 1'b0, 16'h8001, 16'h0, 16'h0138);
    chk_op(CAF_OP_RRC, 1'b1, 1'b1, 16'h1234, 16'h0, 16'h0001);
    chk_op(CAF_OP_RRC, 1'b1, 1'b0, 16'h12f1, 16'h0, 16'h0031);
  endtask : t_rotate

  task automatic t_subtract();
    chk_op(CAF_OP_SBC, 1'b0, 1'b0, 16'h0000, 16'h0, 16'h0038);
    chk_op(CAF_OP_SBC, 1'b1, 1'b1, 16'h3380, 16'h0, 16'h0000);
    chk_op(CAF_OP_SUB, 1'b0, 1'b0, 16'h0005, 16'h0007, 16'h0);
    chk_op(CAF_OP_SUB, 1'b0, 1'b0, 16'h8000, 16'h0001, 16'h0);
    chk_op(CAF_OP_SUBTRACT_WITH_CARRY, 1'b0, 1'b0, 16'h0005, 16'h0005, 16'h1);
    chk_op(CAF_OP_SUBTRACT_WITH_CARRY, 1'b1, 1'b1, 16'h0107, 16'h0205, 16'h0);
  endtask : t_subtract

  task automatic t_flags();
    chk_op(CAF_OP_SET_CARRY_OP, 1'b0, 1'b0, 16'h1111, 16'h0, 16'h0038);
    chk_op(CAF_OP_SET_ZERO_OP, 1'b0, 1'b0, 16'h2222, 16'h0, 16'h0105);
    chk_op(CAF_OP_SET_NEGATIVE_OP, 1'b0, 1'b0, 16'h3333, 16'h0, 16'h0033);
  endtask : t_flags

  task automatic t_misc();
    chk_op(CAF_OP_BYTE_SWAP_OP, 1'b0, 1'b0, 16'h40bf, 16'h0, 16'h013f);
    chk_op(CAF_OP_SXT, 1'b0, 1'b1, 16'h0080, 16'h0, 16'h0100);
    chk_op(CAF_OP_SXT, 1'b0, 1'b1, 16'h7f00, 16'h0, 16'h0139);
    chk_op(CAF_OP_TST, 1'b0, 1'b0, 16'h0000, 16'h0, 16'h0100);
    chk_op(CAF_OP_TST, 1'b1, 1'b1, 16'h1280, 16'h0, 16'h0002);
    chk_op(CAF_OP_XOR, 1'b0, 1'b0, 16'h8000, 16'h8001, 16'h0);
    chk_op(CAF_OP_XOR, 1'b1, 1'b1, 16'h55ff, 16'h00ff, 16'h1);
  endtask : t_misc

  function automatic logic [4:0] cyc_ref(input caf_ev_t ev, input caf_am_t am);
    logic lng;
    logic [3:0] n;
    lng = am inside {CAF_AM_IDX, CAF_AM_SYM, CAF_AM_ABS};
    case (ev)
      CAF_EV_INTERRUPT_RETURN_OP: n = 4'h5;
      CAF_EV_IRQ: n = 4'h6;
      CAF_EV_FMT2: n = (am == CAF_AM_REG) ? 4'h1 : lng ? 4'h4 : 4'h3;
      CAF_EV_PUSH: n = (am == CAF_AM_REG) ? 4'h3 : lng ? 4'h5 : 4'h4;
      CAF_EV_CALL: n = (am inside {CAF_AM_REG, CAF_AM_IND}) ? 4'h4 : 4'h5;
      default: n = 4'h4;
    endcase
    // immediate and the three long modes carry one extension word
    return {lng || am == CAF_AM_IMM, n};
  endfunction : cyc_ref

  // each event; all modes only for the format (bar immediate), push and call events; operation varied to show it does not count
  task automatic t_cycles();
    caf_ev_t ev;
    caf_am_t am;
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 7; i++) begin
      for (int j = 0; j < 7; j++) begin
        ev = caf_ev_t'(i);
        am = caf_am_t'(j);
        if ((ev == CAF_EV_FMT2 && am == CAF_AM_IMM) || (i < 4 && j > 0))
          continue;
        exec(caf_op_t'((i + j) % 12), 1'b0, 1'b1, ev, am, 16'h1234,
             16'h0f0f, 16'h0000);
        u_bus.bus_read(CAF_A_CYC, d, r);
        check("cycles", d, {27'h0, cyc_ref(ev, am)});
      end
    end
  endtask : t_cycles

  // cut a hang short; the whole run needs under a thousand cycles
  initial begin
    repeat (40000) @(posedge aclk);
    n_mismatch++;
    conclude();
  end

  initial begin
    aresetn = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_bus();
    t_rotate();
    t_subtract();
    t_flags();
    t_misc();
    t_cycles();
    conclude();
  end
endmodule : tb_top
